// file: src/hpi_device.sv
module hpi_device #(
    parameter int DP_CYC = hpi_pkg::DP_DELAY_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // host link
    hpi_if.dev               bus,
    // protocol logic side
    input  wire logic        proto_busy,
    output logic             proto_yield,
    input  wire logic        dma_need,
    output logic             dma_owned,
    // internal memory bus
    output logic [15:0]      int_addr,
    output logic [15:0]      int_wdata,
    output logic             int_we,
    output logic             int_re,
    output logic             int_mem,
    input  wire logic [15:0] int_rdata
);
    initial begin
        if (DP_CYC < 1 || DP_CYC > 15) begin
            $error("DP_CYC out of range");
        end
    end

    typedef struct packed {
        hpi_pkg::dev_state_t st;
        logic [1:0]          cnt;
        logic [15:0]         addr_hold;
        logic [15:0]         cyc_addr;
        logic [15:0]         dout;
        logic                doe_n;
        logic                ready_n;
        logic                cyc_n;
        logic                strb_rel;
        logic [7:0]          hold_lo;
        logic [7:0]          hold_hi;
        logic [15:0]         iaddr;
        logic [15:0]         iwdata;
        logic                iwe;
        logic                ire;
        logic                imem;
        logic                is_read;
        logic [3:0]          wait_cnt;
        logic                yield;
        logic                req_n;
        logic                own_n;
    } dev_regs_t;

    localparam dev_regs_t DEV_RST = '{
        st: hpi_pkg::DEV_IDLE, cnt: hpi_pkg::CNT_ADDR, addr_hold: hpi_pkg::RST_WORD,
        cyc_addr: hpi_pkg::RST_WORD, dout: hpi_pkg::RST_WORD, doe_n: 1'b1, ready_n: 1'b1,
        cyc_n: 1'b1, strb_rel: 1'b0, hold_lo: 8'h00, hold_hi: 8'h00, iaddr: hpi_pkg::RST_WORD,
        iwdata: hpi_pkg::RST_WORD, iwe: 1'b0, ire: 1'b0, imem: 1'b0, is_read: 1'b0,
        wait_cnt: 4'h0, yield: 1'b0, req_n: 1'b1, own_n: 1'b1
    };

    dev_regs_t r;
    dev_regs_t r_nxt;

    // falling-edge latch of select and direction
    logic lat_valid_r;
    logic lat_mem_r;
    logic lat_rd_r;

    logic        request;
    logic        pin_read;
    logic        eff_read;
    logic        eff_mem;
    logic        follow;
    logic [15:0] eff_addr;
    logic [15:0] word_addr;
    logic        lane_hi;
    logic        trig;
    logic [15:0] word_in;
    logic [15:0] rd_word;
    logic [7:0]  byte_in;

    always_ff @(negedge core_clk) begin
        if (sys_rst) begin
            lat_valid_r <= 1'b0;
            lat_mem_r   <= 1'b0;
            lat_rd_r    <= 1'b0;
        end else if (r.st == hpi_pkg::DEV_IDLE) begin
            lat_valid_r <= 1'b0;
        end else if (!lat_valid_r) begin
            lat_valid_r <= 1'b1;
            lat_mem_r   <= bus.mem_reg;
            lat_rd_r    <= pin_read;
        end
    end

    always_comb begin
        request   = !bus.select_n && !bus.data_strobe_n;
        pin_read  = bus.polarity_sel ? bus.rd_wr : !bus.rd_wr;
        eff_read  = lat_valid_r ? lat_rd_r : pin_read;
        eff_mem   = lat_valid_r ? lat_mem_r : bus.mem_reg;
        follow    = bus.transparent || bus.address_hold_control;
        eff_addr  = follow ? bus.host_address_bus : r.addr_hold;
        word_addr = bus.byte_mode ? {1'b0, r.cyc_addr[15:1]} : r.cyc_addr;
        lane_hi   = r.cyc_addr[0];
        // trigger strap high: low byte starts the word transfer
        trig      = !bus.byte_mode || (lane_hi != bus.trigger_sel);
        byte_in   = bus.host_data_bus[7:0];
        word_in   = lane_hi ? {byte_in, r.hold_lo} : {r.hold_hi, byte_in};
        rd_word   = trig ? int_rdata : {r.hold_hi, r.hold_lo};
    end

    always_comb begin
        r_nxt     = r;
        r_nxt.iwe = 1'b0;
        r_nxt.ire = 1'b0;
        // address latch tracks pins while control is high
        if (bus.address_hold_control) begin
            r_nxt.addr_hold = bus.host_address_bus;
        end
        r_nxt.req_n = !dma_need;
        r_nxt.own_n = !(dma_need && !r.req_n && !bus.bus_grant_n);
        unique case (r.st)
            hpi_pkg::DEV_IDLE: begin
                // strap high: host waits on ready; strap low: no acknowledge, ready rests low
                r_nxt.ready_n  = bus.zero_wait;
                r_nxt.doe_n    = 1'b1;
                r_nxt.strb_rel = 1'b0;
                r_nxt.yield    = 1'b0;
                r_nxt.wait_cnt = 4'h0;
                if (request && !proto_busy) begin
                    r_nxt.st    = hpi_pkg::DEV_ACT;
                    r_nxt.cyc_n = 1'b0;
                    r_nxt.cnt   = hpi_pkg::CNT_ADDR;
                    if (!bus.zero_wait) begin
                        r_nxt.ready_n = 1'b0;
                    end
                end else if (request && bus.transparent) begin
                    // protocol side is asked to step aside after a bounded wait
                    if (r.wait_cnt == 4'(DP_CYC)) begin
                        // hold the count so the yield request stays up until served
                        r_nxt.wait_cnt = r.wait_cnt;
                        r_nxt.yield = 1'b1;
                    end else begin
                        r_nxt.wait_cnt = r.wait_cnt + 4'h1;
                    end
                end
            end
            hpi_pkg::DEV_ACT: begin
                r_nxt.cnt      = r.cnt + 2'h1;
                r_nxt.yield    = 1'b0;
                r_nxt.strb_rel = r.strb_rel || bus.data_strobe_n;
                // zero-wait host may drop its strobe early; show busy only while the strobe is still held
                r_nxt.ready_n  = !bus.zero_wait ? !r_nxt.strb_rel : 1'b1;
                if (r.cnt == hpi_pkg::CNT_ADDR) begin
                    r_nxt.cyc_addr = eff_addr;
                end
                if (r.cnt == hpi_pkg::CNT_XFER) begin
                    r_nxt.is_read = eff_read;
                    r_nxt.imem    = eff_mem;
                    if (!eff_mem) begin
                        r_nxt.iaddr = {11'h000, word_addr[hpi_pkg::REG_AW-1:0]};
                    end else if (bus.transparent) begin
                        r_nxt.iaddr = word_addr;
                    end else begin
                        r_nxt.iaddr = {4'h0, word_addr[hpi_pkg::RAM_AW-1:0]};
                    end
                    if (!eff_read && bus.byte_mode) begin
                        if (lane_hi) begin
                            r_nxt.hold_hi = byte_in;
                        end else begin
                            r_nxt.hold_lo = byte_in;
                        end
                    end
                    r_nxt.iwdata = bus.byte_mode ? word_in : bus.host_data_bus;
                    r_nxt.iwe    = !eff_read && trig;
                    r_nxt.ire    = eff_read && trig;
                end
                if (r.cnt == hpi_pkg::CNT_READY) begin
                    r_nxt.ready_n = 1'b0;
                    if (r.is_read) begin
                        if (bus.byte_mode) begin
                            r_nxt.dout = {8'h00, lane_hi ? rd_word[15:8] : rd_word[7:0]};
                            if (trig) begin
                                r_nxt.hold_hi = int_rdata[15:8];
                                r_nxt.hold_lo = int_rdata[7:0];
                            end
                        end else begin
                            r_nxt.dout = int_rdata;
                        end
                    end
                    if (r_nxt.strb_rel) begin
                        r_nxt.st    = hpi_pkg::DEV_IDLE;
                        r_nxt.cyc_n = 1'b1;
                    end else begin
                        r_nxt.st    = hpi_pkg::DEV_HOLD;
                        r_nxt.doe_n = !r.is_read;
                    end
                end
            end
            hpi_pkg::DEV_HOLD: begin
                if (bus.data_strobe_n) begin
                    r_nxt.st      = hpi_pkg::DEV_IDLE;
                    r_nxt.cyc_n   = 1'b1;
                    r_nxt.ready_n = bus.zero_wait;
                    r_nxt.doe_n   = 1'b1;
                end
            end
            default: begin
                r_nxt = DEV_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r <= DEV_RST;
        end else begin
            r <= r_nxt;
        end
    end

    assign bus.host_cycle_active_n = r.cyc_n;
    assign bus.transfer_done_n     = r.ready_n;
    assign bus.dev_data_out        = r.dout;
    assign bus.dev_data_oe_n       = r.doe_n;
    assign bus.bus_request_n       = r.req_n;
    assign bus.bus_owned_n         = r.own_n;
    assign proto_yield             = r.yield;
    assign dma_owned               = !r.own_n;
    assign int_addr                = r.iaddr;
    assign int_wdata               = r.iwdata;
    assign int_we                  = r.iwe;
    assign int_re                  = r.ire;
    assign int_mem                 = r.imem;
endmodule

// file: include/hpi_pkg.sv
package hpi_pkg;
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 16;
    localparam int RAM_AW      = 12;
    localparam int REG_AW      = 5;
    localparam int CLK_NS      = 20;
    localparam int DP_DELAY_NS = 250;
    // longest wait rounds down
    localparam int DP_DELAY_CYC = (DP_DELAY_NS / CLK_NS) < 1 ? 1 : (DP_DELAY_NS / CLK_NS);
    // cycle counter values after start edge
    localparam logic [1:0] CNT_ADDR  = 2'h0;
    localparam logic [1:0] CNT_XFER  = 2'h1;
    localparam logic [1:0] CNT_READY = 2'h2;
    // zero-wait host samples read data this many edges after start
    localparam logic [2:0] ZW_SAMPLE = 3'h3;
    // controller software registers
    localparam logic [2:0] OFS_CTRL   = 3'h0;
    localparam logic [2:0] OFS_ADDR   = 3'h1;
    localparam logic [2:0] OFS_WDATA  = 3'h2;
    localparam logic [2:0] OFS_RDATA  = 3'h3;
    localparam logic [2:0] OFS_STATUS = 3'h4;
    localparam logic [2:0] OFS_PAGE   = 3'h5;
    localparam int CTRL_GO    = 0;
    localparam int CTRL_READ  = 1;
    localparam int CTRL_MEM   = 2;
    localparam int CTRL_GRANT = 3;
    localparam logic [15:0] RST_WORD = 16'h0000;
    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_ACT  = 3'b010,
        DEV_HOLD = 3'b100
    } dev_state_t;
    typedef enum logic [2:0] {
        CTL_IDLE = 3'b001,
        CTL_STRB = 3'b010,
        CTL_REL  = 3'b100
    } ctl_state_t;
endpackage

// file: include/hpi_if.sv
interface hpi_if;
    // straps
    logic        polarity_sel;
    logic        zero_wait;
    logic        transparent;
    logic        byte_mode;
    logic        trigger_sel;
    // cycle control
    logic        select_n;
    logic        data_strobe_n;
    logic        rd_wr;
    logic        mem_reg;
    logic        address_hold_control;
    logic [15:0] host_address_bus;
    logic        host_cycle_active_n;
    logic        transfer_done_n;
    // data bus, resolved here from the enables
    logic [15:0] host_data_out;
    logic        host_data_oe_n;
    logic [15:0] dev_data_out;
    logic        dev_data_oe_n;
    logic [15:0] host_data_bus;
    // bus arbitration
    logic        bus_request_n;
    logic        bus_grant_n;
    logic        bus_owned_n;
    // undriven bus reads as pulled up
    assign host_data_bus = !dev_data_oe_n ? dev_data_out :
                           !host_data_oe_n ? host_data_out : 16'hffff;
    modport dev (
        input  polarity_sel, zero_wait, transparent, byte_mode, trigger_sel,
        input  select_n, data_strobe_n, rd_wr, mem_reg, address_hold_control, host_address_bus,
        output host_cycle_active_n, transfer_done_n, dev_data_out, dev_data_oe_n,
        input  host_data_bus, bus_grant_n,
        output bus_request_n, bus_owned_n
    );
    modport host (
        input  polarity_sel, zero_wait, transparent, byte_mode, trigger_sel,
        output select_n, data_strobe_n, rd_wr, mem_reg, address_hold_control, host_address_bus,
        input  host_cycle_active_n, transfer_done_n, host_data_bus, bus_request_n, bus_owned_n,
        output host_data_out, host_data_oe_n, bus_grant_n
    );
endinterface

// file: src/hpi_controller.sv
module hpi_controller (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // software port
    input  wire logic [2:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_we,
    input  wire logic        sw_re,
    output logic [15:0]      sw_rdata,
    // page bits above the 16-bit address during device ownership
    output logic [15:0]      page_out,
    output logic             page_valid,
    // host link
    hpi_if.host              bus
);
    typedef struct packed {
        hpi_pkg::ctl_state_t st;
        logic [2:0]          cnt;
        logic                rd;
        logic                mem;
        logic                grant_en;
        logic [15:0]         addr;
        logic [15:0]         wdata;
        logic [15:0]         rdata;
        logic [15:0]         page;
        logic [15:0]         sw_rd;
        logic                strb_n;
        logic                oe_n;
        logic                grant_n;
    } ctl_regs_t;

    localparam ctl_regs_t CTL_RST = '{
        st: hpi_pkg::CTL_IDLE, cnt: 3'h0, rd: 1'b0, mem: 1'b0, grant_en: 1'b0,
        addr: hpi_pkg::RST_WORD, wdata: hpi_pkg::RST_WORD, rdata: hpi_pkg::RST_WORD,
        page: hpi_pkg::RST_WORD, sw_rd: hpi_pkg::RST_WORD, strb_n: 1'b1, oe_n: 1'b1, grant_n: 1'b1
    };

    ctl_regs_t r;
    ctl_regs_t r_nxt;
    logic      done_seen;
    logic      idle_ready;

    always_comb begin
        // zero-wait device shows no acknowledge; sample by count instead
        done_seen  = !bus.zero_wait ? (!bus.host_cycle_active_n && r.cnt == hpi_pkg::ZW_SAMPLE)
                                   : !bus.transfer_done_n;
        idle_ready = bus.host_cycle_active_n && (bus.transfer_done_n == bus.zero_wait);
        r_nxt      = r;
        unique case (sw_addr)
            hpi_pkg::OFS_CTRL:   r_nxt.sw_rd = {12'h000, r.grant_en, r.mem, r.rd, r.st != hpi_pkg::CTL_IDLE};
            hpi_pkg::OFS_ADDR:   r_nxt.sw_rd = r.addr;
            hpi_pkg::OFS_WDATA:  r_nxt.sw_rd = r.wdata;
            hpi_pkg::OFS_RDATA:  r_nxt.sw_rd = r.rdata;
            hpi_pkg::OFS_STATUS: r_nxt.sw_rd = {13'h0000, !bus.bus_request_n, !bus.bus_owned_n,
                                                r.st != hpi_pkg::CTL_IDLE};
            hpi_pkg::OFS_PAGE:   r_nxt.sw_rd = r.page;
            default:             r_nxt.sw_rd = 16'h0000;
        endcase
        if (!sw_re) begin
            r_nxt.sw_rd = 16'h0000;
        end
        if (sw_we) begin
            unique case (sw_addr)
                hpi_pkg::OFS_CTRL:  r_nxt.grant_en = sw_wdata[hpi_pkg::CTRL_GRANT];
                hpi_pkg::OFS_ADDR:  r_nxt.addr = sw_wdata;
                hpi_pkg::OFS_WDATA: r_nxt.wdata = sw_wdata;
                hpi_pkg::OFS_PAGE:  r_nxt.page = sw_wdata;
                default:            r_nxt.grant_en = r.grant_en;
            endcase
        end
        // grant only between own cycles; held while the device keeps asking
        r_nxt.grant_n = !(!bus.bus_request_n && (!r.grant_n ||
                          (r.grant_en && r.st == hpi_pkg::CTL_IDLE)));
        unique case (r.st)
            hpi_pkg::CTL_IDLE: begin
                if (sw_we && sw_addr == hpi_pkg::OFS_CTRL && sw_wdata[hpi_pkg::CTRL_GO] && r.grant_n) begin
                    r_nxt.st     = hpi_pkg::CTL_STRB;
                    r_nxt.rd     = sw_wdata[hpi_pkg::CTRL_READ];
                    r_nxt.mem    = sw_wdata[hpi_pkg::CTRL_MEM];
                    r_nxt.strb_n = 1'b0;
                    r_nxt.oe_n   = sw_wdata[hpi_pkg::CTRL_READ];
                    r_nxt.cnt    = 3'h0;
                    r_nxt.grant_n = 1'b1;
                end
            end
            hpi_pkg::CTL_STRB: begin
                if (!bus.host_cycle_active_n) begin
                    r_nxt.cnt = r.cnt + 3'h1;
                end
                if (done_seen) begin
                    if (r.rd) begin
                        r_nxt.rdata = bus.host_data_bus;
                    end
                    r_nxt.st     = hpi_pkg::CTL_REL;
                    r_nxt.strb_n = 1'b1;
                    r_nxt.oe_n   = 1'b1;
                end
            end
            hpi_pkg::CTL_REL: begin
                if (idle_ready) begin
                    r_nxt.st = hpi_pkg::CTL_IDLE;
                end
            end
            default: begin
                r_nxt = CTL_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r <= CTL_RST;
        end else begin
            r <= r_nxt;
        end
    end

    assign sw_rdata                 = r.sw_rd;
    assign bus.select_n             = r.strb_n;
    assign bus.data_strobe_n        = r.strb_n;
    assign bus.rd_wr                = r.rd ? bus.polarity_sel : !bus.polarity_sel;
    assign bus.mem_reg              = r.mem;
    assign bus.address_hold_control = 1'b1;
    assign bus.host_address_bus     = r.addr;
    assign bus.host_data_out        = r.wdata;
    assign bus.host_data_oe_n       = r.oe_n;
    assign bus.bus_grant_n          = r.grant_n;
    assign page_out                 = bus.bus_owned_n ? 16'h0000 : r.page;
    assign page_valid               = !bus.bus_owned_n;
endmodule

// file: dv/hpi_properties.sv
module hpi_properties (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic zero_wait,
    input wire logic polarity_sel,
    input wire logic select_n,
    input wire logic data_strobe_n,
    input wire logic rd_wr,
    input wire logic host_cycle_active_n,
    input wire logic transfer_done_n,
    input wire logic dev_data_oe_n,
    input wire logic bus_grant_n,
    input wire logic bus_request_n,
    input wire logic bus_owned_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence nz_start_s;
        zero_wait && $fell(host_cycle_active_n);
    endsequence
    sequence ready_third_s;
        transfer_done_n [*3] ##1 !transfer_done_n;
    endsequence
    a_start_on_req: assert property ($fell(host_cycle_active_n) |->
        $past(!select_n && !data_strobe_n)) else $error("cycle began without select and strobe");
    a_ready_third_edge: assert property (nz_start_s |-> ready_third_s)
        else $error("ready not on third edge");
    a_end_releases: assert property (
        zero_wait && !host_cycle_active_n && !transfer_done_n && data_strobe_n
        |=> host_cycle_active_n && transfer_done_n && dev_data_oe_n) else $error("cycle end not released");
    a_zw_idle_low: assert property ((!zero_wait && host_cycle_active_n) [*4] |-> !transfer_done_n)
        else $error("zero wait ready not low while idle");
    a_owned_after_grant: assert property ($fell(bus_owned_n) |->
        $past(!bus_grant_n && !bus_request_n)) else $error("owned without grant and request");
    a_read_drives_bus: assert property (
        zero_wait && $fell(transfer_done_n) && rd_wr == polarity_sel |-> !dev_data_oe_n)
        else $error("read data not driven with ready");
    a_write_quiet_bus: assert property (
        zero_wait && !host_cycle_active_n && !transfer_done_n && rd_wr != polarity_sel |-> dev_data_oe_n)
        else $error("device drove bus on a write");
    a_done_in_cycle: assert property (zero_wait && !transfer_done_n |-> !host_cycle_active_n)
        else $error("ready low outside a cycle");
    a_idle_bus_free: assert property (host_cycle_active_n && $past(host_cycle_active_n) |-> dev_data_oe_n)
        else $error("data bus driven while idle");
endmodule

// file: dv/host_processor_interface_tb.sv
module host_processor_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk;
    logic        sys_rst;
    logic [2:0]  sw_addr;
    logic [15:0] sw_wdata;
    logic        sw_we;
    logic        sw_re;
    logic [15:0] sw_rdata;
    logic [15:0] page_out;
    logic        page_valid;
    logic        proto_busy;
    logic        proto_yield;
    logic        dma_need;
    logic        dma_owned;
    logic [15:0] int_addr;
    logic [15:0] int_wdata;
    logic        int_we;
    logic        int_re;
    logic        int_mem;
    logic [15:0] mem_m [0:65535];
    logic [15:0] last_addr;
    logic        last_mem;
    logic [15:0] seed;
    int          miscompares;
    int          checked;
    int          cycles;
    hpi_if bus ();
    // small count keeps the yield wait short
    hpi_device #(.DP_CYC(4)) hpi_device_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
        .proto_busy(proto_busy), .proto_yield(proto_yield), .dma_need(dma_need), .dma_owned(dma_owned),
        .int_addr(int_addr), .int_wdata(int_wdata), .int_we(int_we), .int_re(int_re), .int_mem(int_mem),
        .int_rdata(mem_m[int_addr]));
    hpi_controller hpi_controller_i (.core_clk(core_clk), .sys_rst(sys_rst), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .page_out(page_out),
        .page_valid(page_valid), .bus(bus));
    hpi_properties hpi_properties_i (.core_clk(core_clk), .sys_rst(sys_rst), .zero_wait(bus.zero_wait),
        .polarity_sel(bus.polarity_sel), .select_n(bus.select_n), .data_strobe_n(bus.data_strobe_n),
        .rd_wr(bus.rd_wr), .host_cycle_active_n(bus.host_cycle_active_n),
        .transfer_done_n(bus.transfer_done_n), .dev_data_oe_n(bus.dev_data_oe_n),
        .bus_grant_n(bus.bus_grant_n), .bus_request_n(bus.bus_request_n), .bus_owned_n(bus.bus_owned_n));
    // internal ram and register model
    always @(posedge core_clk) begin
        if (int_we || int_re) begin
            last_addr <= int_addr;
            last_mem <= int_mem;
        end
        if (int_we) begin
            mem_m[int_addr] <= int_wdata;
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_addr(input logic mem, input logic tr, input logic [15:0] a);
        if (!mem) return a & 16'h001f;
        return tr ? a : (a & 16'h0fff);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic sw_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_we <= 1'b1;
        @(posedge core_clk);
        sw_we <= 1'b0;
    endtask
    task automatic sw_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_re <= 1'b1;
        @(posedge core_clk);
        sw_re <= 1'b0;
        @(posedge core_clk);
        d = sw_rdata;
    endtask
    task automatic do_reset(input logic pol, input logic zw, input logic tr);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        bus.polarity_sel <= pol;
        bus.zero_wait <= zw;
        bus.transparent <= tr;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask
    task automatic xfer_start(input logic rd, input logic mem, input logic [15:0] a, input logic [15:0] d);
        sw_wr(hpi_pkg::OFS_ADDR, a);
        sw_wr(hpi_pkg::OFS_WDATA, d);
        sw_wr(hpi_pkg::OFS_CTRL, {13'h0000, mem, rd, 1'b1});
    endtask
    task automatic xfer_wait(output logic [15:0] q);
        logic [15:0] s;
        int n;
        n = 0;
        s = 16'h0001;
        while (s[0] !== 1'b0 && n < 60) begin
            sw_rd(hpi_pkg::OFS_CTRL, s);
            n++;
        end
        check({15'h0000, s[0]}, 16'h0000);
        sw_rd(hpi_pkg::OFS_RDATA, q);
    endtask
    // write then read back one location
    task automatic round(input logic mem, input logic [15:0] a);
        logic [15:0] d;
        logic [15:0] q;
        seed = lfsr(seed);
        d = seed;
        xfer_start(1'b0, mem, a, d);
        xfer_wait(q);
        check(last_addr, exp_addr(mem, bus.transparent, a));
        check({15'h0000, last_mem}, {15'h0000, mem});
        check(mem_m[exp_addr(mem, bus.transparent, a)], d);
        xfer_start(1'b1, mem, a, 16'h0000);
        xfer_wait(q);
        check(q, d);
    endtask
    task automatic wait_owned(input logic v);
        int n;
        n = 0;
        while (dma_owned !== v && n < 20) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    initial begin
        logic [15:0] q;
        sys_rst = 1'b1;
        bus.polarity_sel = 1'b1;
        bus.zero_wait = 1'b1;
        bus.transparent = 1'b0;
        bus.byte_mode = 1'b0;
        bus.trigger_sel = 1'b1;
        sw_addr = 3'h0;
        sw_wdata = 16'h0000;
        sw_we = 1'b0;
        sw_re = 1'b0;
        proto_busy = 1'b0;
        dma_need = 1'b0;
        seed = 16'h0f8b;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        for (int m = 0; m < 4; m++) begin
            do_reset(m[0], 1'b1, m[1]);
            round(1'b1, 16'hffff);
            round(1'b1, 16'h1000);
            for (int i = 0; i < 3; i++) begin
                seed = lfsr(seed);
                round(1'b1, seed);
            end
            round(1'b0, 16'h00ff);
            // protocol holds the ram while the host asks
            proto_busy <= 1'b1;
            xfer_start(1'b0, 1'b1, 16'h0010, 16'h1234);
            repeat (12) @(posedge core_clk);
            check({15'h0000, bus.host_cycle_active_n}, 16'h0001);
            check({15'h0000, proto_yield}, {15'h0000, m[1]});
            proto_busy <= 1'b0;
            xfer_wait(q);
            check(mem_m[16'h0010], 16'h1234);
            $display("test mode %0d done", m);
        end
        do_reset(1'b0, 1'b0, 1'b0);
        repeat (4) @(posedge core_clk);
        check({15'h0000, bus.transfer_done_n}, 16'h0000);
        round(1'b1, 16'h0a5a);
        round(1'b0, 16'h0003);
        // byte lanes: high lane is held until the low lane moves the word
        bus.byte_mode <= 1'b1;
        seed = lfsr(seed);
        xfer_start(1'b0, 1'b1, 16'h0021, {8'h00, seed[15:8]});
        xfer_wait(q);
        xfer_start(1'b0, 1'b1, 16'h0020, {8'h00, seed[7:0]});
        xfer_wait(q);
        check(mem_m[16'h0010], seed);
        check(last_addr, 16'h0010);
        xfer_start(1'b1, 1'b1, 16'h0020, 16'h0000);
        xfer_wait(q);
        check(q, {8'h00, seed[7:0]});
        xfer_start(1'b1, 1'b1, 16'h0021, 16'h0000);
        xfer_wait(q);
        check(q, {8'h00, seed[15:8]});
        bus.byte_mode <= 1'b0;
        $display("test zero wait done");
        do_reset(1'b1, 1'b1, 1'b0);
        seed = lfsr(seed);
        sw_wr(hpi_pkg::OFS_PAGE, seed);
        sw_wr(hpi_pkg::OFS_CTRL, 16'h0008);
        dma_need <= 1'b1;
        wait_owned(1'b1);
        check({15'h0000, dma_owned}, 16'h0001);
        check({15'h0000, bus.bus_request_n}, 16'h0000);
        check(page_out, seed);
        dma_need <= 1'b0;
        wait_owned(1'b0);
        check({15'h0000, page_valid}, 16'h0000);
        $display("test dma done");
        print_verdict();
    end
endmodule
